// *** imwc_consts.svh ***
`ifndef IMWC_CONSTS_SVH
`define IMWC_CONSTS_SVH
// =====================================================================
// Register map
`define IMWC_ADDR_W          20
`define IMWC_MODE_ADDR       20'hf0231
`define IMWC_LOW_ADDR        20'hf0232
`define IMWC_HIGH_ADDR       20'hf0233
// =====================================================================
// Mode control field positions
`define IMWC_WAKE_BIT        7
`define IMWC_CLK_LVL_BIT     5
`define IMWC_DAT_LVL_BIT     4
`define IMWC_SPEED_BIT       3
`define IMWC_FILTER_BIT      2
// =====================================================================
// Reset values
`define IMWC_MODE_RST        8'h00
`define IMWC_LOW_RST         8'hff
`define IMWC_HIGH_RST        8'hff
// =====================================================================
// Timing
`define IMWC_CLK_PERIOD_NS   20
`define IMWC_WAKE_SETUP_CYC  3
`endif

// *** imwc_pkg.sv ***
`default_nettype none
package imwc_pkg;
   // Output clock generator phases
   typedef enum logic [1:0] {
      IMWC_GEN_IDLE,
      IMWC_GEN_LOW,
      IMWC_GEN_HIGH
   } imwc_gen_t;
endpackage : imwc_pkg
`default_nettype wire

// *** imwc_link.sv ***
`timescale 1ns/1ps
`default_nettype none
// Pin-facing logic on the link clock: sampling, noise filter and
// start/stop detection. Events leave this domain as toggles.
module imwc_link (
   input  wire logic link_clk_in,
   input  wire logic rst_n_in,
   input  wire logic scl_pin_in,
   input  wire logic sda_pin_in,
   input  wire logic filter_on_in,
   output logic      scl_level_out,
   output logic      sda_level_out,
   output logic      start_tgl_out,
   output logic      stop_tgl_out
);
   logic [1:0] rst_sync_q;
   logic [1:0] scl_sync_q;
   logic [1:0] sda_sync_q;
   logic [1:0] flt_sync_q;
   logic       scl_prev_q;
   logic       sda_prev_q;
   logic       link_rst_n;
   logic       scl_acc;
   logic       sda_acc;
   logic       start_det;
   logic       stop_det;

   // =====================================================================
   // Synchronisers
   // Reset comes from the other clock; it is only released after two edges
   assign link_rst_n = rst_sync_q[1];
   always_ff @(posedge link_clk_in) begin
      rst_sync_q <= {rst_sync_q[0], rst_n_in};
      scl_sync_q <= {scl_sync_q[0], scl_pin_in};
      sda_sync_q <= {sda_sync_q[0], sda_pin_in};
      flt_sync_q <= {flt_sync_q[0], filter_on_in};
   end

   // =====================================================================
   // Noise filter: a new level is taken only once seen on two samples
   assign scl_acc = !flt_sync_q[1] || (scl_sync_q[1] == scl_prev_q); // [R13]
   assign sda_acc = !flt_sync_q[1] || (sda_sync_q[1] == sda_prev_q); // [R13]

   // Start: data falls while clock high; stop: data rises while clock high
   assign start_det = scl_level_out && scl_acc && scl_sync_q[1]
                      && sda_acc && sda_level_out && !sda_sync_q[1];
   assign stop_det  = scl_level_out && scl_acc && scl_sync_q[1]
                      && sda_acc && !sda_level_out && sda_sync_q[1];

   // Filtered levels and event toggles
   always_ff @(posedge link_clk_in) begin
      if (!link_rst_n) begin
         scl_prev_q    <= 1'b1;
         sda_prev_q    <= 1'b1;
         scl_level_out <= 1'b1;
         sda_level_out <= 1'b1;
         start_tgl_out <= 1'b0;
         stop_tgl_out  <= 1'b0;
      end else begin
         scl_prev_q <= scl_sync_q[1];
         sda_prev_q <= sda_sync_q[1];
         if (scl_acc) begin
            scl_level_out <= scl_sync_q[1];
         end
         if (sda_acc) begin
            sda_level_out <= sda_sync_q[1];
         end
         if (start_det) begin
            start_tgl_out <= !start_tgl_out;
         end
         if (stop_det) begin
            stop_tgl_out <= !stop_tgl_out;
         end
      end
   end
endmodule : imwc_link
`default_nettype wire

// *** imwc_mode_timing.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "imwc_consts.svh"
// Operation
// (R1) Reset clears the mode control register to zero.
// (R2) Clock and data level sense bits are read-only; writes ignored.
// (R3) Software changes mode fields, except wake enable, only while disabled.
// (R4) Wake enable keeps address detection alive during stop; else halted.
// (R5) Software waits three clock cycles after wake enable before stopping.
// (R6) Software clears wake enable before releasing stretch or writing data.
// (R7) Address or extension interrupt timing is the same with wake enabled.
// (R8) No stop-condition interrupt while wake enable is set.
// (R9) Software sets wake enable only when not taking part in traffic.
// (R10) Clock sense bit follows the clock pin when enabled, else zero.
// (R11) Data sense bit follows the data pin when enabled, else zero.
// (R12) Speed select: zero standard 100 kbps, one fast 400 kbps.
// (R13) Filter bit switches input noise filter; software uses it only fast.
// (R14) Output clock rate does not depend on the noise filter; here the high phase waits on the filtered clock line.
// (R15) Peripheral clock at least 1 MHz standard, 3.5 MHz fast.
// (R16) Low-width register sets clock low time; resets to all ones.
// (R17) Data is held for one quarter of the programmed low time.
// (R18) High-width register sets clock high time; resets to all ones.
// (R19) Software writes width registers only while disabled, byte wide.
// (R20) Start-seen flag sets whenever a start condition is detected; here it sets only while the unit is enabled.
// (R21) Width values count peripheral clock cycles.
module imwc_mode_timing
   import imwc_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        link_clk_in,
   input  wire logic [19:0] addr_in,
   input  wire logic        wr_en_in,
   input  wire logic        rd_en_in,
   input  wire logic [7:0]  wdata_in,
   output logic [7:0]       rdata_out,
   input  wire logic        bus_unit_enable_in,
   input  wire logic        stop_irq_enable_in,
   input  wire logic        cpu_stop_in,
   input  wire logic        addr_match_evt_in,
   input  wire logic        ext_code_evt_in,
   input  wire logic        start_seen_clr_in,
   input  wire logic        gen_run_in,
   input  wire logic        scl_pin_in,
   input  wire logic        sda_pin_in,
   output logic             scl_out,
   output logic             scl_oe_n_out,
   output logic             sda_update_out,
   output logic             addr_detect_run_out,
   output logic             addr_irq_out,
   output logic             stop_irq_out,
   output logic             start_seen_out,
   output logic             speed_fast_out,
   output logic             wake_enable_out
);
   // =====================================================================
   // Declarations
   logic [7:0] mode_q;
   logic [7:0] wl_q;
   logic [7:0] wh_q;
   logic [7:0] rdata_q;
   logic [7:0] cnt_q;
   logic [7:0] cnt_d;
   logic [2:0] start_sync_q;
   logic [2:0] stop_sync_q;
   logic [1:0] scl_sync_q;
   logic [1:0] sda_sync_q;
   logic       clk_lvl_q;
   logic       dat_lvl_q;
   logic       start_seen_q;
   logic       scl_oe_n_q;
   logic       sda_update_q;
   logic       stop_irq_q;
   logic       link_scl;
   logic       link_sda;
   logic       link_start;
   logic       link_stop;
   logic       start_evt;
   logic       stop_evt;
   logic       sel_mode;
   logic       sel_low;
   logic       sel_high;
   logic       wr_cfg_ok;
   logic [7:0] mode_rd;
   logic [7:0] rd_mux;
   logic       low_done;
   logic       high_done;
   logic       hold_hit;
   imwc_gen_t  gen_q;
   imwc_gen_t  gen_d;

   // Width compare shared by both clock phases
   function automatic logic width_done(input logic [7:0] cnt,
                                       input logic [7:0] lim);
      width_done = (cnt >= lim);
   endfunction : width_done

   // =====================================================================
   // Link side
   imwc_link u_link (
      .link_clk_in   (link_clk_in),
      .rst_n_in      (rst_n_in),
      .scl_pin_in    (scl_pin_in),
      .sda_pin_in    (sda_pin_in),
      .filter_on_in  (mode_q[`IMWC_FILTER_BIT]),
      .scl_level_out (link_scl),
      .sda_level_out (link_sda),
      .start_tgl_out (link_start),
      .stop_tgl_out  (link_stop)
   );

   // =====================================================================
   // Crossings into the peripheral clock: levels by two flops, events
   // by toggle; only the second stage and beyond are looked at
   always_ff @(posedge clk_in) begin
      scl_sync_q   <= {scl_sync_q[0], link_scl};
      sda_sync_q   <= {sda_sync_q[0], link_sda};
      start_sync_q <= {start_sync_q[1:0], link_start};
      stop_sync_q  <= {stop_sync_q[1:0], link_stop};
   end
   assign start_evt = start_sync_q[2] ^ start_sync_q[1];
   assign stop_evt  = stop_sync_q[2] ^ stop_sync_q[1];

   // =====================================================================
   // Register decode
   assign sel_mode  = (addr_in == `IMWC_MODE_ADDR);
   assign sel_low   = (addr_in == `IMWC_LOW_ADDR);
   assign sel_high  = (addr_in == `IMWC_HIGH_ADDR);
   // Config is frozen while running so timing cannot tear mid-frame
   assign wr_cfg_ok = wr_en_in && !bus_unit_enable_in; // [R3] [R19]
   // Sense bits come from live state, never from stored write data
   assign mode_rd   = {mode_q[7], 1'b0, clk_lvl_q, dat_lvl_q,
                       mode_q[3:2], 2'b00}; // [R2]
   assign rd_mux    = sel_mode ? mode_rd :
                      sel_low  ? wl_q    :
                      sel_high ? wh_q    : 8'h00;

   // Mode register: wake bit always writable, rest only when disabled
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         mode_q <= `IMWC_MODE_RST; // [R1]
      end else if (wr_en_in && sel_mode) begin
         mode_q[`IMWC_WAKE_BIT] <= wdata_in[`IMWC_WAKE_BIT];
         if (wr_cfg_ok) begin
            mode_q[`IMWC_SPEED_BIT]  <= wdata_in[`IMWC_SPEED_BIT];  // [R12]
            mode_q[`IMWC_FILTER_BIT] <= wdata_in[`IMWC_FILTER_BIT]; // [R13]
         end
      end
   end

   // Width registers
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         wl_q <= `IMWC_LOW_RST;  // [R16]
         wh_q <= `IMWC_HIGH_RST; // [R18]
      end else begin
         if (wr_cfg_ok && sel_low) begin
            wl_q <= wdata_in;
         end
         if (wr_cfg_ok && sel_high) begin
            wh_q <= wdata_in;
         end
      end
   end

   // Read data, registered; unmapped addresses read zero
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         rdata_q <= 8'h00;
      end else if (rd_en_in) begin
         rdata_q <= rd_mux;
      end
   end

   // =====================================================================
   // Pin sense bits, forced low while the unit is off
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         clk_lvl_q <= 1'b0;
         dat_lvl_q <= 1'b0;
      end else begin
         clk_lvl_q <= bus_unit_enable_in && scl_sync_q[1]; // [R10]
         dat_lvl_q <= bus_unit_enable_in && sda_sync_q[1]; // [R11]
      end
   end

   // =====================================================================
   // Start-seen flag: a start in the clearing cycle still wins
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         start_seen_q <= 1'b0;
      end else if (bus_unit_enable_in && start_evt) begin
         start_seen_q <= 1'b1; // [R20]
      end else if (start_seen_clr_in || !bus_unit_enable_in) begin
         start_seen_q <= 1'b0;
      end
   end

   // =====================================================================
   // Wakeup and interrupts. The match interrupt is combinational from
   // the event so its timing does not move with the wake bit.
   assign addr_detect_run_out = bus_unit_enable_in
                                && (!cpu_stop_in
                                    || mode_q[`IMWC_WAKE_BIT]); // [R4]
   assign addr_irq_out = addr_detect_run_out
                         && (addr_match_evt_in || ext_code_evt_in); // [R7]
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         stop_irq_q <= 1'b0;
      end else begin
         stop_irq_q <= bus_unit_enable_in && stop_evt && stop_irq_enable_in
                       && !mode_q[`IMWC_WAKE_BIT]; // [R8]
      end
   end

   // =====================================================================
   // Output clock generator; counts run on the peripheral clock, but the high
   // phase counts only once the filtered clock line reads high, so the filter can stretch it
   assign low_done  = width_done(cnt_q, wl_q);             // [R16] [R21]
   assign high_done = width_done(cnt_q, wh_q);             // [R18] [R21]
   assign hold_hit  = (cnt_q == {2'b00, wl_q[7:2]});       // [R17]

   always_comb begin
      gen_d = gen_q;
      cnt_d = cnt_q;
      case (gen_q)
         IMWC_GEN_IDLE: begin
            cnt_d = 8'h01;
            if (gen_run_in && bus_unit_enable_in) begin
               gen_d = IMWC_GEN_LOW;
            end
         end
         IMWC_GEN_LOW: begin
            cnt_d = cnt_q + 8'h01;
            if (low_done) begin
               gen_d = IMWC_GEN_HIGH;
               cnt_d = 8'h01;
            end
         end
         IMWC_GEN_HIGH: begin
            // A slave holding the line low stretches the high phase
            if (scl_sync_q[1]) begin
               cnt_d = cnt_q + 8'h01; // [R14]
            end
            if (high_done) begin
               gen_d = gen_run_in ? IMWC_GEN_LOW : IMWC_GEN_IDLE;
               cnt_d = 8'h01;
            end
         end
         default: begin
            gen_d = IMWC_GEN_IDLE;
            cnt_d = 8'h01;
         end
      endcase
      if (!bus_unit_enable_in) begin
         gen_d = IMWC_GEN_IDLE;
         cnt_d = 8'h01;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         gen_q        <= IMWC_GEN_IDLE;
         cnt_q        <= 8'h01;
         scl_oe_n_q   <= 1'b1;
         sda_update_q <= 1'b0;
      end else begin
         gen_q        <= gen_d;
         cnt_q        <= cnt_d;
         scl_oe_n_q   <= (gen_d != IMWC_GEN_LOW);
         sda_update_q <= (gen_q == IMWC_GEN_LOW) && hold_hit; // [R17]
      end
   end

   // =====================================================================
   // Outputs
   assign rdata_out       = rdata_q;
   assign scl_out         = 1'b0;
   assign scl_oe_n_out    = scl_oe_n_q;
   assign sda_update_out  = sda_update_q;
   assign stop_irq_out    = stop_irq_q;
   assign start_seen_out  = start_seen_q;
   assign speed_fast_out  = mode_q[`IMWC_SPEED_BIT]; // [R12]
   assign wake_enable_out = mode_q[`IMWC_WAKE_BIT];

   // =====================================================================
   // Assertions
   mode_reset_a: assert property (@(posedge clk_in) // [R1]
      $rose(rst_n_in) |-> (mode_q == 8'h00))
      else $error("mode register not cleared by reset");
   sense_ro_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      rd_en_in && sel_mode |=> (rdata_out[5:4] == $past(mode_rd[5:4]))
      && ($past(mode_rd[5:4]) == {$past(clk_lvl_q), $past(dat_lvl_q)}))
      else $error("sense bits not read from live state"); // [R2]
   stop_halt_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      cpu_stop_in && !mode_q[7] |-> !addr_detect_run_out) // [R4]
      else $error("detection runs in stop without wake");
   irq_timing_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      bus_unit_enable_in && !cpu_stop_in && addr_match_evt_in
      |-> addr_irq_out) // [R7]
      else $error("match interrupt delayed or lost");
   no_stop_irq_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      $past(mode_q[7]) |-> !stop_irq_out) // [R8]
      else $error("stop interrupt while wake enabled");
   clk_sense_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !bus_unit_enable_in |=> !clk_lvl_q && !dat_lvl_q) // [R10]
      else $error("sense bits high while disabled");
   dat_sense_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      bus_unit_enable_in |=> (dat_lvl_q == $past(sda_sync_q[1]))) // [R11]
      else $error("data sense bit does not follow pin");
   start_flag_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      bus_unit_enable_in && start_evt |=> start_seen_q) // [R20]
      else $error("start condition not flagged");
   low_width_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      gen_q == IMWC_GEN_LOW && cnt_q < wl_q && bus_unit_enable_in
      |=> gen_q == IMWC_GEN_LOW && !scl_oe_n_out) // [R16]
      else $error("clock low phase ended early");
   high_width_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      gen_q == IMWC_GEN_HIGH && cnt_q < wh_q && bus_unit_enable_in
      |=> gen_q == IMWC_GEN_HIGH) // [R18]
      else $error("clock high phase ended early");
   data_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      gen_q == IMWC_GEN_LOW && cnt_q == {2'b00, wl_q[7:2]}
      |=> sda_update_out) // [R17]
      else $error("data hold point missed");
endmodule : imwc_mode_timing
`default_nettype wire

// *** imwc_bus_peer.sv ***
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Other party on the two-wire bus: pulls lines low, never drives high
module imwc_bus_peer (
   input  wire logic clk_in,
   output logic      scl_low_out,
   output logic      sda_low_out
);
   // Both lines start released so the pull-ups hold them high
   initial begin
      scl_low_out = 1'b0;
      sda_low_out = 1'b0;
   end

   // Each level is held 12 cycles so the slower link sampler sees it
   task automatic drive(input logic scl_low, input logic sda_low);
      @(posedge clk_in);
      scl_low_out <= scl_low;
      sda_low_out <= sda_low;
      repeat (12) @(posedge clk_in);
   endtask : drive

   // Start: data falls while the clock line stays high
   task automatic bus_start();
      drive(1'b0, 1'b0);
      drive(1'b0, 1'b1);
   endtask : bus_start

   // Stop: data rises while the clock line stays high
   task automatic bus_stop();
      drive(1'b0, 1'b1);
      drive(1'b0, 1'b0);
   endtask : bus_stop
endmodule : imwc_bus_peer
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "imwc_consts.svh"
// =====================================================================
// Compare helper: counts every check, reports a miss at once
`define CHK(nm, e, g) \
   begin \
      n_tests++; \
      if ((g) !== (e)) begin \
         bad_count++; \
         $display("[FAIL] %s expected %h seen %h", nm, e, g); \
      end \
   end
module testbench;
   // ==================================================================
   // Signals
   logic        clk_in, rst_n_in, link_clk_in, wr_en_in, rd_en_in;
   logic [19:0] addr_in;
   logic [7:0]  wdata_in, rdata_out;
   logic        bus_unit_enable_in, stop_irq_enable_in, cpu_stop_in;
   logic        addr_match_evt_in, ext_code_evt_in, start_seen_clr_in;
   logic        gen_run_in, scl_out, scl_oe_n_out, sda_update_out;
   logic        addr_detect_run_out, addr_irq_out, stop_irq_out;
   logic        start_seen_out, speed_fast_out, wake_enable_out;
   logic        peer_scl_low, peer_sda_low;
   wire         scl_w, sda_w;
   int          bad_count, n_tests, stop_cnt, lo, hi, upd, n, wl, wh;
   int unsigned rs;
   int          per_q[$];

   // Open-drain wires with pull-ups: low if any party pulls low
   assign scl_w = ((scl_oe_n_out === 1'b0) ? scl_out : 1'b1) & ~peer_scl_low;
   assign sda_w = ~peer_sda_low;

   imwc_mode_timing u_imwc_mode_timing (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .link_clk_in(link_clk_in),
      .addr_in(addr_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
      .wdata_in(wdata_in), .rdata_out(rdata_out),
      .bus_unit_enable_in(bus_unit_enable_in),
      .stop_irq_enable_in(stop_irq_enable_in), .cpu_stop_in(cpu_stop_in),
      .addr_match_evt_in(addr_match_evt_in),
      .ext_code_evt_in(ext_code_evt_in),
      .start_seen_clr_in(start_seen_clr_in), .gen_run_in(gen_run_in),
      .scl_pin_in(scl_w), .sda_pin_in(sda_w), .scl_out(scl_out),
      .scl_oe_n_out(scl_oe_n_out), .sda_update_out(sda_update_out),
      .addr_detect_run_out(addr_detect_run_out),
      .addr_irq_out(addr_irq_out), .stop_irq_out(stop_irq_out),
      .start_seen_out(start_seen_out), .speed_fast_out(speed_fast_out),
      .wake_enable_out(wake_enable_out));

   imwc_bus_peer u_imwc_bus_peer (
      .clk_in(clk_in), .scl_low_out(peer_scl_low),
      .sda_low_out(peer_sda_low));

   // ==================================================================
   // Clocks: link clock offset so the two never keep a fixed phase
   // 50 MHz sits well above the slowest legal peripheral clock
   initial begin
      clk_in = 1'b0;
      forever #(`IMWC_CLK_PERIOD_NS / 2) clk_in = ~clk_in;
   end
   initial begin
      link_clk_in = 1'b0;
      #7;
      forever #16 link_clk_in = ~link_clk_in;
   end
   // Stop interrupt pulses are counted in the background
   always @(posedge clk_in) begin
      if (stop_irq_out === 1'b1) stop_cnt++;
   end

   // ==================================================================
   // Helpers
   function automatic int unsigned rnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction : rnd

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_of_test

   task automatic lost(input string nm);
      bad_count++;
      $display("[FAIL] %s expected event seen none", nm);
      end_of_test();
   endtask : lost

   task automatic reg_wr(input logic [19:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_in  <= a;
      wdata_in <= d;
      wr_en_in <= 1'b1;
      @(posedge clk_in);
      wr_en_in <= 1'b0;
   endtask : reg_wr

   // Read data is registered, so it is looked at one edge after the strobe
   task automatic rd_chk(input string nm, input logic [19:0] a,
                         input logic [7:0] e);
      @(posedge clk_in);
      addr_in  <= a;
      rd_en_in <= 1'b1;
      @(posedge clk_in);
      rd_en_in <= 1'b0;
      #1;
      `CHK(nm, e, rdata_out)
   endtask : rd_chk

   task automatic evt_chk(input logic [1:0] s, input logic e);
      @(posedge clk_in);
      {ext_code_evt_in, addr_match_evt_in} <= s;
      #1;
      `CHK("addr irq", e, addr_irq_out)
      @(posedge clk_in);
      {ext_code_evt_in, addr_match_evt_in} <= 2'b00;
   endtask : evt_chk

   // One start then one stop from the other party
   task automatic frame(input int stops);
      stop_cnt = 0;
      u_imwc_bus_peer.bus_start();
      #1;
      `CHK("start seen", 1'b1, start_seen_out)
      @(posedge clk_in);
      start_seen_clr_in <= 1'b1;
      @(posedge clk_in);
      start_seen_clr_in <= 1'b0;
      u_imwc_bus_peer.bus_stop();
      repeat (8) @(posedge clk_in);
      #1;
      `CHK("stop irq count", stops, stop_cnt)
      `CHK("start cleared", 1'b0, start_seen_out)
   endtask : frame

   // ==================================================================
   // Main sequence
   initial begin
      {rst_n_in, wr_en_in, rd_en_in, bus_unit_enable_in} = 4'h0;
      {cpu_stop_in, addr_match_evt_in, ext_code_evt_in} = 3'h0;
      {start_seen_clr_in, gen_run_in} = 2'h0;
      stop_irq_enable_in = 1'b1;
      addr_in = 20'h00000;
      wdata_in = 8'h00;
      rs = 35;
      repeat (3) @(posedge clk_in);
      rst_n_in <= 1'b1;
      repeat (10) @(posedge clk_in);
      rd_chk("mode reset", `IMWC_MODE_ADDR, 8'h00);
      rd_chk("low reset", `IMWC_LOW_ADDR, 8'hff);
      rd_chk("high reset", `IMWC_HIGH_ADDR, 8'hff);
      rd_chk("unmapped", 20'hf0234, 8'h00);
      $display("test reset values done");
      reg_wr(`IMWC_MODE_ADDR, 8'hff);
      rd_chk("mode fields", `IMWC_MODE_ADDR, 8'h8c);
      `CHK("fast mode", 1'b1, speed_fast_out)
      reg_wr(`IMWC_MODE_ADDR, 8'h00);
      #1;
      `CHK("standard mode", 1'b0, speed_fast_out)
      $display("test mode fields done");
      @(posedge clk_in);
      bus_unit_enable_in <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         u_imwc_bus_peer.drive(i[1], i[0]);
         n = {26'h0, ~i[1], ~i[0], 4'h0};
         rd_chk("sense", `IMWC_MODE_ADDR, n[7:0]);
      end
      u_imwc_bus_peer.drive(1'b0, 1'b0);
      bus_unit_enable_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      rd_chk("sense off", `IMWC_MODE_ADDR, 8'h00);
      $display("test line sense done");
      `CHK("idle before wake", 1'b0, start_seen_out)
      @(posedge clk_in);
      bus_unit_enable_in <= 1'b1;
      reg_wr(`IMWC_MODE_ADDR, 8'h88);
      rd_chk("wake only", `IMWC_MODE_ADDR, 8'hb0);
      `CHK("wake out", 1'b1, wake_enable_out)
      repeat (`IMWC_WAKE_SETUP_CYC) @(posedge clk_in);
      cpu_stop_in <= 1'b1;
      @(posedge clk_in);
      #1;
      `CHK("detect in stop", 1'b1, addr_detect_run_out)
      for (int s = 1; s < 3; s++) evt_chk(s[1:0], 1'b1);
      frame(0);
      reg_wr(`IMWC_MODE_ADDR, 8'h00);
      #1;
      `CHK("halt in stop", 1'b0, addr_detect_run_out)
      `CHK("wake cleared", 1'b0, wake_enable_out)
      for (int s = 1; s < 3; s++) evt_chk(s[1:0], 1'b0);
      cpu_stop_in <= 1'b0;
      for (int s = 1; s < 3; s++) evt_chk(s[1:0], 1'b1);
      frame(1);
      // With the stop interrupt disabled no pulse may appear either
      @(posedge clk_in);
      stop_irq_enable_in <= 1'b0;
      frame(0);
      @(posedge clk_in);
      bus_unit_enable_in <= 1'b0;
      $display("test wake and events done");
      wl = 8 + int'(rnd() % 40);
      wh = 4 + int'(rnd() % 20);
      for (int f = 0; f < 2; f++) begin
         reg_wr(`IMWC_MODE_ADDR, (f == 1) ? 8'h0c : 8'h08);
         reg_wr(`IMWC_LOW_ADDR, wl[7:0]);
         reg_wr(`IMWC_HIGH_ADDR, wh[7:0]);
         rd_chk("low width", `IMWC_LOW_ADDR, wl[7:0]);
         rd_chk("high width", `IMWC_HIGH_ADDR, wh[7:0]);
         @(posedge clk_in);
         bus_unit_enable_in <= 1'b1;
         gen_run_in <= 1'b1;
         n = 0;
         while (scl_oe_n_out !== 1'b0 && n < 40) begin
            @(posedge clk_in);
            #1;
            n++;
         end
         if (n >= 40) lost("clock low start");
         lo = 0;
         upd = -1;
         while (scl_oe_n_out === 1'b0 && lo < 300) begin
            if (sda_update_out === 1'b1) upd = lo;
            lo++;
            @(posedge clk_in);
            #1;
         end
         hi = 0;
         while (scl_oe_n_out === 1'b1 && hi < 300) begin
            hi++;
            @(posedge clk_in);
            #1;
         end
         if (hi >= 300) lost("clock high end");
         `CHK("low cycles", wl, lo)
         `CHK("hold point", wl / 4, upd)
         `CHK("high band", 1'b1, hi >= wh && hi <= wh + 12)
         per_q.push_back(lo + hi);
         @(posedge clk_in);
         gen_run_in <= 1'b0;
         bus_unit_enable_in <= 1'b0;
      end
      n = per_q[0] - per_q[1];
      `CHK("period vs filter", 1'b1, n >= -3 && n <= 3)
      $display("test clock widths done");
      end_of_test();
   end
endmodule : testbench
`default_nettype wire
